// file: inc/mrs_pkg.sv
// shared constants for the manual relay stepper and error queue
package mrs_pkg;
   localparam int NUM_CH = 6;                      // channel positions per relay
   localparam int QDEPTH = 10;                     // error queue depth
   localparam logic [2:0] FOUR_POLE_FIRST = 3'h1;  // first used index in 4-pole mode (ch2)
   localparam logic [2:0] FOUR_POLE_LAST = 3'h5;   // last used index in 4-pole mode (ch6)
   localparam logic [2:0] FOUR_POLE_SKIP = 3'h3;   // unused middle index in 4-pole mode (ch4)
   localparam logic [2:0] SIX_POLE_LAST = 3'h5;    // last used index in 6-pole mode (ch6)
   localparam logic [2:0] CH_NONE = 3'h7;          // no channel closed
   localparam logic signed [11:0] CODE_NO_ERROR = 12'sh000;   // +000
   localparam logic signed [11:0] CODE_OVERFLOW = -12'sd350;  // queue overflow
   localparam logic signed [11:0] CODE_INTERNAL = 12'sd900;   // internal system error
   typedef enum logic [1:0] {MRS_CLS_NONE, MRS_CLS_ERR, MRS_CLS_STAT, MRS_CLS_SYS} mrs_cls_t;
   typedef enum logic [2:0] {
      MRS_GRP_OTHER, MRS_GRP_QUERY, MRS_GRP_HEADER, MRS_GRP_CHAR, MRS_GRP_STRING,
      MRS_GRP_NUMERIC
   } mrs_grp_t;
endpackage

// file: verif/mrs_panel.sv
// operator panel model: one toggle push per request
`timescale 1ns/1ps
module mrs_panel (
   input wire logic clk_sys,     // system clock
   input wire logic push,        // request one push
   input wire logic [1:0] sel,   // 0 sw1 open, 1 sw1 step, 2 sw2 open, 3 sw2 step
   output logic busy,            // push in progress
   output logic [3:0] pins       // switch levels, bit order as sel
);
   logic [3:0] cnt_ff = 4'h0;    // cycles into the push
   logic [1:0] sel_ff = 2'h0;    // latched switch
   // hold high 3 cycles, then rest so pushes stay well apart
   always_ff @(negedge clk_sys) begin
      if (push && cnt_ff == 4'h0) begin
         cnt_ff <= 4'h1;
         sel_ff <= sel;
      end else if (cnt_ff != 4'h0) begin
         cnt_ff <= (cnt_ff == 4'h9) ? 4'h0 : cnt_ff + 4'h1;
      end
   end
   assign busy = cnt_ff != 4'h0;
   assign pins = (busy && cnt_ff < 4'h4) ? 4'h1 << sel_ff : 4'h0;
endmodule

// file: verif/tb_mrs_top.sv
// self-checking bench for the manual relay stepper and error queue
`timescale 1ns/1ps
module tb_mrs_top;
   import mrs_pkg::*;
   logic clk_sys = 1'b0, sys_rst = 1'b1, push = 1'b0, busy;
   logic [1:0] sel = 2'h0;
   logic [3:0] pins;
   logic four_pole_out = 1'b0, four_pole_in = 1'b0, host_open_all = 1'b0;
   logic host_close_out = 1'b0, host_close_in = 1'b0, err_valid = 1'b0;
   logic [2:0] host_ch = 3'h0;
   logic signed [11:0] err_code = 12'sh000;
   logic q_read = 1'b0, q_clear = 1'b0, stat_enable = 1'b0, err_enable = 1'b1;
   logic en_write = 1'b0, q_rvalid_ff;
   logic [2:0] out_ch_ff, in_ch_ff, q_grp_ff;
   logic [NUM_CH-1:0] out_led_ff, in_led_ff;
   logic [15:0] out_count_ff, in_count_ff;
   logic signed [11:0] q_data_ff;
   logic [1:0] q_cls_ff;
   logic [3:0] q_count_ff;
   logic [2:0] m_ch [2] = '{CH_NONE, CH_NONE};  // expected channel per relay
   logic [15:0] m_cnt [2] = '{16'h0000, 16'h0000}; // expected host tallies
   logic signed [11:0] mq [$];                    // expected queue contents
   logic m_sen = 1'b0, m_een = 1'b1;              // expected admission flags
   int num_errors = 0, total_checks = 0, cyc = 0;
   int codes [23] = '{-440, -430, -420, -410, -113, -112, -111, -110, -148, -144, -141,
      -140, -158, -154, -151, -150, -128, -124, -123, -121, -120, -222, 900};

   mrs_panel PANEL (.clk_sys(clk_sys), .push(push), .sel(sel), .busy(busy), .pins(pins));
   mrs_top #(.DEPTH(QDEPTH)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .sw1_open(pins[0]), .sw1_step(pins[1]), .sw2_open(pins[2]), .sw2_step(pins[3]),
      .four_pole_out(four_pole_out), .four_pole_in(four_pole_in),
      .host_open_all(host_open_all), .host_close_out(host_close_out),
      .host_close_in(host_close_in), .host_ch(host_ch), .err_valid(err_valid),
      .err_code(err_code), .q_read(q_read), .q_clear(q_clear), .stat_enable(stat_enable),
      .err_enable(err_enable), .en_write(en_write), .out_ch_ff(out_ch_ff),
      .in_ch_ff(in_ch_ff), .out_led_ff(out_led_ff), .in_led_ff(in_led_ff),
      .out_count_ff(out_count_ff), .in_count_ff(in_count_ff), .q_data_ff(q_data_ff),
      .q_cls_ff(q_cls_ff), .q_grp_ff(q_grp_ff), .q_rvalid_ff(q_rvalid_ff),
      .q_count_ff(q_count_ff));

   // 100 ns clock
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // hang guard, the full run needs about 700 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 6000) begin
         num_errors++;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   // next used position; open, last or unused goes to first used
   function automatic logic [2:0] step_of(input logic [2:0] c, input logic fp);
      logic [2:0] first, last;
      first = fp ? FOUR_POLE_FIRST : 3'h0;
      last = fp ? FOUR_POLE_LAST : SIX_POLE_LAST;
      if (c == CH_NONE || c >= last || c < first || (fp && c == FOUR_POLE_SKIP)) return first;
      if (fp && 3'(c + 3'h1) == FOUR_POLE_SKIP) return 3'(c + 3'h2);
      return 3'(c + 3'h1);
   endfunction
   function automatic logic [NUM_CH-1:0] led_of(input logic [2:0] c);
      return (c == CH_NONE) ? '0 : NUM_CH'(1) << c;
   endfunction
   function automatic logic [2:0] grp_of(input int c);
      if (c inside {[-440:-410]}) return MRS_GRP_QUERY;
      if (c inside {[-113:-110]}) return MRS_GRP_HEADER;
      if (c inside {[-148:-140]}) return MRS_GRP_CHAR;
      if (c inside {[-158:-150]}) return MRS_GRP_STRING;
      if (c inside {[-128:-120]}) return MRS_GRP_NUMERIC;
      return MRS_GRP_OTHER;
   endfunction
   function automatic logic [1:0] cls_of(input int c);
      return (c == 0) ? MRS_CLS_STAT : (c == -350) ? MRS_CLS_SYS : MRS_CLS_ERR;
   endfunction

   task automatic check_relays();
      check(out_ch_ff, m_ch[0], "out ch");
      check(in_ch_ff, m_ch[1], "in ch");
      check(out_led_ff, led_of(m_ch[0]), "out led");
      check(in_led_ff, led_of(m_ch[1]), "in led");
      check(out_count_ff, m_cnt[0], "out count");
      check(in_count_ff, m_cnt[1], "in count");
      check(q_count_ff, mq.size(), "q count");
   endtask
   task automatic do_push(input logic [1:0] s);
      int k;
      if (s[0]) m_ch[s[1]] = step_of(m_ch[s[1]], s[1] ? four_pole_in : four_pole_out);
      else m_ch[s[1]] = CH_NONE;
      sel <= s;
      push <= 1'b1;
      @(negedge clk_sys) push <= 1'b0;
      @(negedge clk_sys);
      for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
      check_relays();
   endtask
   task automatic do_host(input int r, input logic [2:0] c, input logic all);
      host_ch = c;
      host_open_all = all;
      host_close_out = !all && r == 0;
      host_close_in = !all && r == 1;
      @(negedge clk_sys) {host_open_all, host_close_out, host_close_in} = 3'h0;
      if (all) m_ch = '{CH_NONE, CH_NONE};
      else begin
         m_ch[r] = c;
         m_cnt[r]++;
      end
      @(negedge clk_sys) check_relays();
   endtask
   task automatic do_err(input int c);
      err_code = 12'(c);
      err_valid = 1'b1;
      @(negedge clk_sys) err_valid = 1'b0;
      if ((c == 0 ? m_sen : m_een) && mq.size() < QDEPTH)
         mq.push_back(mq.size() == QDEPTH - 1 ? CODE_OVERFLOW : 12'(c));
      check(q_count_ff, mq.size(), "push count");
      @(negedge clk_sys);
   endtask
   task automatic do_read();
      logic signed [11:0] e;
      e = (mq.size() == 0) ? CODE_NO_ERROR : mq.pop_front();
      q_read = 1'b1;
      @(negedge clk_sys) q_read = 1'b0;
      check(q_rvalid_ff, 1'b1, "rvalid");
      check(q_data_ff, e, "read code");
      check(q_cls_ff, cls_of(e), "class");
      check(q_grp_ff, grp_of(e), "group");
      @(negedge clk_sys);
   endtask
   task automatic set_en(input logic s, input logic e);
      {stat_enable, err_enable, en_write} = {s, e, 1'b1};
      {m_sen, m_een} = {s, e};
      @(negedge clk_sys) en_write = 1'b0;
      @(negedge clk_sys);
   endtask

   initial begin
      int i;
      i = $urandom(32'h799e8955);
      repeat (10) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge clk_sys) check_relays();
      // wrap on six poles, skip unused on four poles, open one side only
      for (i = 0; i < 7; i++) do_push(2'h1);
      four_pole_in = 1'b1;
      for (i = 0; i < 5; i++) do_push(2'h3);
      do_push(2'h0);
      do_host(0, 3'h2, 1'b0);
      do_host(1, 3'h4, 1'b0);
      do_push(2'h1);
      do_host(0, 3'h0, 1'b1);
      // random mix of pushes, pole changes and host closes
      for (i = 0; i < 30; i++) begin
         four_pole_out = $urandom_range(0, 1);
         four_pole_in = $urandom_range(0, 1);
         if ($urandom_range(0, 3) == 0) do_host($urandom_range(0, 1), $urandom_range(0, 5),
            $urandom_range(0, 4) == 0);
         else do_push($urandom_range(0, 3));
      end
      // status code kept out until enabled, empty read gives no error
      do_read();
      do_err(0);
      set_en(1'b1, 1'b1);
      do_err(0);
      do_read();
      // overfill, then drain in order
      for (i = 0; i < 12; i++) do_err(codes[$urandom_range(0, 22)]);
      for (i = 0; i < 11; i++) do_read();
      foreach (codes[j]) begin
         do_err(codes[j]);
         do_read();
      end
      do_err(-110);
      q_clear = 1'b1;
      @(negedge clk_sys) q_clear = 1'b0;
      mq.delete();
      check(q_count_ff, 4'h0, "clear");
      set_en(1'b0, 1'b0);
      do_err(-113);
      end_sim();
   end
endmodule

// file: verilog/mrs_relay_ctl.sv
// one relay's manual control: open-all and stepping through used channels
`timescale 1ns/1ps
module mrs_relay_ctl import mrs_pkg::*; (
   input wire logic clk_sys,             // system clock
   input wire logic sys_rst,             // async reset, active high
   input wire logic open_pulse,          // one-cycle open-all request
   input wire logic step_pulse,          // one-cycle step request
   input wire logic host_close,          // host closes host_ch this cycle
   input wire logic [2:0] host_ch,       // host channel index
   input wire logic host_open_all,       // host open-all, both relays
   input wire logic four_pole,           // relay is a 4-pole type
   output logic [2:0] ch_ff,             // closed channel index, CH_NONE if open
   output logic [NUM_CH-1:0] led_ff,     // channel indicator leds
   output logic [15:0] count_ff          // host closure tally
);
   logic [2:0] first_ch;    // first used channel
   logic [2:0] last_ch;     // last used channel
   logic [2:0] nxt_ch;      // next closed channel
   logic [NUM_CH-1:0] nxt_led;  // one-hot of nxt_ch
   logic [2:0] plus_one;    // index after the closed one
   logic [2:0] step_to;     // next used index, hopping the unused middle one
   logic off_seq;           // closed channel is the last used one or not on the step sequence
   assign first_ch = four_pole ? FOUR_POLE_FIRST : 3'h0;
   assign last_ch = four_pole ? FOUR_POLE_LAST : SIX_POLE_LAST;
   assign plus_one = 3'(ch_ff + 3'h1);
   assign step_to = (four_pole && plus_one == FOUR_POLE_SKIP) ? 3'(plus_one + 3'h1) : plus_one;
   // open, last or unused positions restart at the first used channel
   assign off_seq = (ch_ff == CH_NONE) || (ch_ff >= last_ch) || (ch_ff < first_ch) ||
                    (four_pole && ch_ff == FOUR_POLE_SKIP);
   // open wins over step; a single closed channel means the old one opens on the same edge the new one closes
   assign nxt_ch = (open_pulse | host_open_all) ? CH_NONE :
                   step_pulse ? (off_seq ? first_ch : step_to) :
                   host_close ? host_ch : ch_ff;
   // leds mirror the closed channel, all dark when open
   always_comb begin
      nxt_led = '0;
      if (nxt_ch != CH_NONE) begin
         nxt_led[nxt_ch] = 1'b1;
      end
   end
   // state registers
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         ch_ff <= CH_NONE;
         led_ff <= '0;
      end else begin
         ch_ff <= nxt_ch;
         led_ff <= nxt_led;
      end
   end
   // only host closures are tallied; manual steps leave the count alone
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count_ff <= 16'h0000;
      end else if (host_close && !open_pulse && !step_pulse && !host_open_all) begin
         count_ff <= count_ff + 16'h0001;
      end
   end
   // no skipped channel closes on a step in 4-pole mode
   property p_skip;
      @(posedge clk_sys) disable iff (sys_rst)
      (four_pole && $rose(step_pulse)) |=> (ch_ff != 3'h0 && ch_ff != FOUR_POLE_SKIP);
   endproperty
   a_skip: assert property (p_skip) else $error("skipped channel closed");
   property p_step_cnt;
      @(posedge clk_sys) disable iff (sys_rst)
      step_pulse |=> $stable(count_ff);
   endproperty
   a_step_cnt: assert property (p_step_cnt) else $error("manual step counted");
   property p_open_led;
      @(posedge clk_sys) disable iff (sys_rst)
      open_pulse |=> (led_ff == '0 && ch_ff == CH_NONE);
   endproperty
   a_open_led: assert property (p_open_led) else $error("leds lit after open");
endmodule

// file: verilog/mrs_top.sv
// manual relay stepper with error classification and error queue
`timescale 1ns/1ps
module mrs_top import mrs_pkg::*; #(
   parameter int DEPTH = QDEPTH  // error queue depth
) (
   input wire logic clk_sys,               // system clock, 10 MHz
   input wire logic sys_rst,               // async reset, active high
   input wire logic sw1_open,              // switch beside relay 1, open-all side
   input wire logic sw1_step,              // switch beside relay 1, step side
   input wire logic sw2_open,              // switch beside relay 2, open-all side
   input wire logic sw2_step,              // switch beside relay 2, step side
   input wire logic four_pole_out,         // output relay is 4-pole
   input wire logic four_pole_in,          // input relay is 4-pole
   input wire logic host_open_all,         // host open-all pulse
   input wire logic host_close_out,        // host close pulse, output relay
   input wire logic host_close_in,         // host close pulse, input relay
   input wire logic [2:0] host_ch,         // host channel index
   input wire logic err_valid,             // error event pulse
   input wire logic signed [11:0] err_code, // event code, signed
   input wire logic q_read,                // queue read pulse
   input wire logic q_clear,               // queue clear pulse
   input wire logic stat_enable,           // set to let status messages in
   input wire logic err_enable,            // set to let error messages in
   input wire logic en_write,              // load stat_enable/err_enable
   output logic [2:0] out_ch_ff,           // output relay closed channel
   output logic [2:0] in_ch_ff,            // input relay closed channel
   output logic [NUM_CH-1:0] out_led_ff,   // output relay leds
   output logic [NUM_CH-1:0] in_led_ff,    // input relay leds
   output logic [15:0] out_count_ff,       // output relay host closures
   output logic [15:0] in_count_ff,        // input relay host closures
   output logic signed [11:0] q_data_ff,   // oldest code, valid after read
   output logic [1:0] q_cls_ff,            // class of q_data_ff
   output logic [2:0] q_grp_ff,            // fault group of q_data_ff
   output logic q_rvalid_ff,               // read answer pulse
   output logic [3:0] q_count_ff           // entries in the queue
);
   // three-stage sync per switch line; stages 2 and 3 agreeing gives the level
   logic [3:0] sw_raw;      // raw switch pins
   logic [3:0] s1_ff;       // first stage
   logic [3:0] s2_ff;       // second stage
   logic [3:0] s3_ff;       // third stage
   logic [3:0] lvl_ff;      // accepted level
   logic [3:0] nxt_lvl;     // next accepted level
   logic [3:0] press;       // one-cycle press pulses
   assign sw_raw = {sw2_step, sw2_open, sw1_step, sw1_open};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         assign nxt_lvl[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : lvl_ff[gi];
      end
   endgenerate
   assign press = nxt_lvl & ~lvl_ff;  // one push gives one pulse
   // synchroniser chain
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
         s3_ff <= 4'h0;
         lvl_ff <= 4'h0;
      end else begin
         s1_ff <= sw_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= nxt_lvl;
      end
   end

   // switch 1 steers the output relay, switch 2 the input relay
   mrs_relay_ctl u_out (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .open_pulse(press[0]),
      .step_pulse(press[1]),
      .host_close(host_close_out),
      .host_ch(host_ch),
      .host_open_all(host_open_all),
      .four_pole(four_pole_out),
      .ch_ff(out_ch_ff),
      .led_ff(out_led_ff),
      .count_ff(out_count_ff)
   );
   mrs_relay_ctl u_in (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .open_pulse(press[2]),
      .step_pulse(press[3]),
      .host_close(host_close_in),
      .host_ch(host_ch),
      .host_open_all(host_open_all),
      .four_pole(four_pole_in),
      .ch_ff(in_ch_ff),
      .led_ff(in_led_ff),
      .count_ff(in_count_ff)
   );

   // class of a code: overflow is system class, zero is status, rest errors
   function automatic mrs_cls_t classify(input logic signed [11:0] c);
      if (c == CODE_OVERFLOW) return MRS_CLS_SYS;
      if (c == CODE_NO_ERROR) return MRS_CLS_STAT;
      return MRS_CLS_ERR;
   endfunction
   // fault group of a code, by listed code values; unlisted codes are other
   function automatic mrs_grp_t group_of(input logic signed [11:0] c);
      if (c == -12'sd440 || c == -12'sd430 || c == -12'sd420 || c == -12'sd410)
         return MRS_GRP_QUERY;
      if (c >= -12'sd113 && c <= -12'sd110) return MRS_GRP_HEADER;
      if (c == -12'sd148 || c == -12'sd144 || c == -12'sd141 || c == -12'sd140)
         return MRS_GRP_CHAR;
      if (c == -12'sd158 || c == -12'sd154 || c == -12'sd151 || c == -12'sd150)
         return MRS_GRP_STRING;
      if (c == -12'sd128 || c == -12'sd124 || c == -12'sd123 || c == -12'sd121 ||
          c == -12'sd120)
         return MRS_GRP_NUMERIC;
      return MRS_GRP_OTHER;
   endfunction

   // enable flags: status off and errors on out of reset
   logic stat_en_ff;  // status messages admitted
   logic err_en_ff;   // error messages admitted
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         stat_en_ff <= 1'b0;
         err_en_ff <= 1'b1;
      end else if (en_write) begin
         stat_en_ff <= stat_enable;
         err_en_ff <= err_enable;
      end
   end

   // error queue; fed only by err_valid, never by the switches
   logic signed [11:0] mem [DEPTH];  // stored codes
   logic [3:0] rd_ptr_ff;            // oldest entry
   logic [3:0] wr_ptr_ff;            // next free entry
   logic [3:0] nxt_count;            // next occupancy
   mrs_cls_t in_cls;                 // class of incoming code
   logic admit;                      // incoming code enabled
   logic do_push;                    // write this cycle
   logic do_pop;                     // pop this cycle
   logic last_slot;                  // one free slot left
   logic signed [11:0] wr_code;      // code actually written
   assign in_cls = classify(err_code);
   assign admit = err_valid && ((in_cls == MRS_CLS_STAT) ? stat_en_ff : err_en_ff);
   assign do_pop = q_read && (q_count_ff != 4'h0);
   // full queue with no pop drops new events; overflow stands last if a lone push filled it
   assign do_push = admit && (q_count_ff < 4'(DEPTH) || do_pop);
   assign last_slot = (q_count_ff == 4'(DEPTH - 1)) && !do_pop;
   assign wr_code = last_slot ? CODE_OVERFLOW : err_code;
   assign nxt_count = 4'(q_count_ff + {3'h0, do_push} - {3'h0, do_pop});

   // ring pointers wrap at DEPTH
   function automatic logic [3:0] inc_ptr(input logic [3:0] p);
      return (p == 4'(DEPTH - 1)) ? 4'h0 : 4'(p + 4'h1);
   endfunction

   // storage write, no reset needed on data
   always_ff @(posedge clk_sys) begin
      if (do_push && !q_clear) begin
         mem[wr_ptr_ff] <= wr_code;
      end
   end
   // pointers and occupancy
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rd_ptr_ff <= 4'h0;
         wr_ptr_ff <= 4'h0;
         q_count_ff <= 4'h0;
      end else if (q_clear) begin
         rd_ptr_ff <= 4'h0;
         wr_ptr_ff <= 4'h0;
         q_count_ff <= 4'h0;
      end else begin
         if (do_push) wr_ptr_ff <= inc_ptr(wr_ptr_ff);
         if (do_pop) rd_ptr_ff <= inc_ptr(rd_ptr_ff);
         q_count_ff <= nxt_count;
      end
   end
   // read answer; an empty queue answers no-error
   logic signed [11:0] rd_code;  // code returned on read
   assign rd_code = do_pop ? mem[rd_ptr_ff] : CODE_NO_ERROR;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         q_data_ff <= CODE_NO_ERROR;
         q_cls_ff <= MRS_CLS_NONE;
         q_grp_ff <= MRS_GRP_OTHER;
         q_rvalid_ff <= 1'b0;
      end else begin
         q_rvalid_ff <= q_read;
         if (q_read) begin
            q_data_ff <= rd_code;
            q_cls_ff <= classify(rd_code);
            q_grp_ff <= group_of(rd_code);
         end
      end
   end

   // manual presses never reach the queue
   property p_manual_status;
      @(posedge clk_sys) disable iff (sys_rst)
      (|press && !err_valid && !q_read && !q_clear) |=> $stable(q_count_ff);
   endproperty
   a_manual_status: assert property (p_manual_status) else $error("switch moved queue");
   property p_depth;
      @(posedge clk_sys) disable iff (sys_rst)
      q_count_ff <= 4'(DEPTH);
   endproperty
   a_depth: assert property (p_depth) else $error("queue over depth");
   property p_stat_block;
      @(posedge clk_sys) disable iff (sys_rst)
      (err_valid && err_code == CODE_NO_ERROR && !stat_en_ff && !q_read && !q_clear)
         |=> $stable(q_count_ff);
   endproperty
   a_stat_block: assert property (p_stat_block) else $error("status msg queued");
   property p_empty_read;
      @(posedge clk_sys) disable iff (sys_rst)
      (q_read && q_count_ff == 4'h0) |=> (q_rvalid_ff && q_data_ff == CODE_NO_ERROR);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read not zero");
   property p_open_other;
      @(posedge clk_sys) disable iff (sys_rst)
      (press[0] && !press[3] && !press[2] && !host_open_all && !host_close_in)
         |=> (out_ch_ff == CH_NONE && $stable(in_ch_ff));
   endproperty
   a_open_other: assert property (p_open_other) else $error("open-all hit other relay");
   property p_host_open;
      @(posedge clk_sys) disable iff (sys_rst)
      host_open_all |=> (out_ch_ff == CH_NONE && in_ch_ff == CH_NONE);
   endproperty
   a_host_open: assert property (p_host_open) else $error("host open-all missed a relay");
   property p_overflow;
      @(posedge clk_sys) disable iff (sys_rst)
      (do_push && last_slot && !q_clear) |=> (q_count_ff == 4'(DEPTH));
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow slot wrong");
   property p_grp;
      @(posedge clk_sys) disable iff (sys_rst)
      (q_read && do_pop && mem[rd_ptr_ff] == -12'sd430) |=> (q_grp_ff == MRS_GRP_QUERY);
   endproperty
   a_grp: assert property (p_grp) else $error("query fault misgrouped");
   // input relay open-all leaves the output relay alone
   property p_in_open;
      @(posedge clk_sys) disable iff (sys_rst)
      (press[2] && !press[0] && !press[1] && !host_open_all && !host_close_out)
         |=> (in_ch_ff == CH_NONE && $stable(out_ch_ff));
   endproperty
   a_in_open: assert property (p_in_open) else $error("open-all hit other relay");
   // host open-all darkens every indicator on both relays
   property p_host_dark;
      @(posedge clk_sys) disable iff (sys_rst)
      host_open_all |=> (out_led_ff == '0 && in_led_ff == '0);
   endproperty
   a_host_dark: assert property (p_host_dark) else $error("leds lit after host open");
   // every read is answered one cycle later, empty or not
   property p_rvalid;
      @(posedge clk_sys) disable iff (sys_rst)
      q_read |=> q_rvalid_ff;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   // occupancy moves by one per lone push or lone pop
   property p_push_count;
      @(posedge clk_sys) disable iff (sys_rst)
      (do_push && !do_pop && !q_clear) |=> (q_count_ff == 4'($past(q_count_ff) + 4'h1));
   endproperty
   a_push_count: assert property (p_push_count) else $error("push not counted");
   property p_pop_count;
      @(posedge clk_sys) disable iff (sys_rst)
      (do_pop && !do_push && !q_clear) |=> (q_count_ff == 4'($past(q_count_ff) - 4'h1));
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("pop not counted");
   // clear empties the queue in one cycle, whatever else arrives
   property p_clear;
      @(posedge clk_sys) disable iff (sys_rst)
      q_clear |=> (q_count_ff == 4'h0);
   endproperty
   a_clear: assert property (p_clear) else $error("clear left entries");
   // a full queue with no read drops further events, so the overflow entry stays last if a lone push filled it
   property p_full_drop;
      @(posedge clk_sys) disable iff (sys_rst)
      (err_valid && q_count_ff == 4'(DEPTH) && !q_read && !q_clear)
         |=> (q_count_ff == 4'(DEPTH));
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full queue grew");
   // a disabled error class keeps error codes out
   property p_err_block;
      @(posedge clk_sys) disable iff (sys_rst)
      (err_valid && err_code != CODE_NO_ERROR && !err_en_ff && !q_read && !q_clear)
         |=> $stable(q_count_ff);
   endproperty
   a_err_block: assert property (p_err_block) else $error("disabled error queued");
   // main scenarios: stepping, skipping, filling and reading back
   c_step: cover property (@(posedge clk_sys) disable iff (sys_rst) press[1] ##3 press[1]);
   c_full: cover property (@(posedge clk_sys) disable iff (sys_rst) q_count_ff == 4'(DEPTH));
   c_read: cover property (@(posedge clk_sys) disable iff (sys_rst) do_pop ##1 q_rvalid_ff);
   c_skip: cover property (@(posedge clk_sys) disable iff (sys_rst)
      (four_pole_in && press[3]) ##1 (in_ch_ff == 3'h4));
   c_ovf_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
      q_rvalid_ff && q_data_ff == CODE_OVERFLOW);
endmodule
